// File: ftp_core.sv
// Processor-side special registers: flags, narrow-data widening, timer, pitch, unpacker.
// Assumes the execution unit presents one instruction code per cycle with instr_valid,
// and that the byte memory port answers a held request with a one-cycle mem_ack.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [RL1] Branch, short branch, call only when status set
// [RL2] Interrupt entry saves flags, return restores them
// [RL3] Integer instr sets, sign-extend instr clears mode
// [RL4] Narrow data zero-filled or sign-extended by mode
// [RL5] Timer decrements on each prescaler wrap
// [RL6] Timer load/read; divider load sets latch, maybe prescaler
// [RL7] Timer wrap raises held level-2 request
// [RL8] Timer idle until first load, then free-runs
// [RL9] Prescaler wrap reloads from preset latch
// [RL10] Prescaler ticks at one sixteenth core clock
// [RL11] Pitch load copies accumulator; counter cleared at start
// [RL12] Counter drops 020h per speech sample
// [RL13] Below zero, pitch value is added back
// [RL14] Level-1 interrupt when counter goes under 200h
// [RL15] Excitation only while counter within 140h..000h
// [RL16] Software keeps accumulator bits 0 and 13 zero
// [RL17] Software keeps pitch values within documented ranges
// [RL18] Unpack init loads pointer, fills shifter, clears count
// [RL19] Bit fetch moves one to eight bits
// [RL20] Empty shifter reloads from pointer, pointer increments
// [RL21] RAM source uses index, no increment
// [RL22] Source chosen by external and RAM mode bits
// [RL23] RAM bit high selects RAM, else ROM; the code picks external memory instead when external_memory_enable_bit is set
// [RL24] Level-2 delivered only with level-2 enable set
// [RL25] Fetched bits right-justified, filled by mode
module ftp_core
	import ftp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire ftp_pkg::ftp_op_t instr_op,
	input wire logic [13:0] acc_in,
	input wire logic [7:0] narrow_in,
	input wire logic [2:0] fetch_len_m1,
	input wire logic [7:0] x_index,
	input wire logic status_we,
	input wire logic status_in,
	input wire logic int_enter,
	input wire logic int_enable,
	input wire logic int_in_service,
	input wire logic level2_ack,
	input wire logic level2_enable_bit,
	input wire logic external_memory_enable_bit,
	input wire logic ram_source_bit,
	input wire logic lattice_synthesis_mode,
	input wire logic speech_start,
	input wire logic sample_tick,
	input wire logic [7:0] mem_data,
	input wire logic mem_ack,
	output logic branch_take,
	output logic status_flag,
	output logic int_mode_flag,
	output logic [13:0] result_data,
	output logic result_we,
	output logic level2_irq,
	output logic level1_irq,
	output logic excitation_on,
	output logic [7:0] event_timer,
	output logic mem_req,
	output ftp_pkg::ftp_src_t mem_src,
	output logic [13:0] mem_addr,
	output logic unpack_busy
);
	import ftp_pkg::*;

	typedef struct packed {
		logic status;
		logic int_mode;
		logic saved_status;
		logic saved_int_mode;
		logic branch;
		logic [13:0] result;
		logic result_we;
		logic irq2_pend;
		logic irq2_req;
		logic [13:0] ptr;
		logic [7:0] shifter;
		logic [3:0] used;
		logic [3:0] want;
		logic [3:0] got;
		logic [7:0] bits;
		ftp_state_t fstate;
		logic init_load;
		logic req;
		ftp_src_t src;
		logic [13:0] addr;
		logic busy;
	} ftp_core_state_t;

	ftp_core_state_t s;
	ftp_core_state_t next_s;
	logic is_op;
	logic [7:0] next_bits;
	logic timer_wrap;

	////////////////////////////////////////////////////////////////////////////////
	// Timer and pitch sub-blocks
	ftp_timer i_ftp_timer (
		.core_clk(core_clk),
		.rst(rst),
		.timer_load(instr_valid && instr_op == OP_TIMER_LOAD),
		.divider_load(instr_valid && instr_op == OP_DIVIDER_LOAD),
		.load_data(acc_in[7:0]),
		.timer_value(event_timer),
		.timer_wrap(timer_wrap)
	);

	ftp_pitch i_ftp_pitch (
		.core_clk(core_clk),
		.rst(rst),
		.pitch_load(instr_valid && instr_op == OP_PITCH_LOAD),
		.pitch_data(acc_in),
		.speech_start(speech_start),
		.sample_tick(sample_tick),
		.lattice_synthesis_mode(lattice_synthesis_mode),
		.level1_irq(level1_irq),
		.excitation_on(excitation_on)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Source of the next shifter byte; RAM overrides the external-memory choice
	function automatic ftp_src_t pick_src(input logic ram_bit, input logic ext_bit);
		if (ram_bit)
			return SRC_RAM;
		else if (ext_bit)
			return SRC_EXT;
		else
			return SRC_ROM;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Flags, instruction results, level-2 request and unpack sequencer
	always_comb
	begin
		next_s = s;
		next_s.branch = 1'b0;
		next_s.result_we = 1'b0;
		is_op = instr_valid;
		next_bits = {s.bits[6:0], s.shifter[7]};

		// Status flag follows the ALU; return restores the saved copy
		if (status_we)
			next_s.status = status_in;
		if (int_enter)
		begin
			next_s.saved_status = s.status; // [RL2]
			next_s.saved_int_mode = s.int_mode; // [RL2]
		end

		if (is_op)
		begin
			case (instr_op)
				OP_BRANCH, OP_SHORT_BRANCH, OP_CALL:
					next_s.branch = s.status; // [RL1]
				OP_INT_RET:
				begin
					next_s.status = s.saved_status; // [RL2]
					next_s.int_mode = s.saved_int_mode; // [RL2]
				end
				OP_INTEGER:
					next_s.int_mode = 1'b1; // [RL3]
				OP_SIGN_EXTEND:
					next_s.int_mode = 1'b0; // [RL3]
				OP_TIMER_READ:
				begin
					next_s.result = ftp_extend(event_timer, NARROW_W, s.int_mode); // [RL6] [RL4]
					next_s.result_we = 1'b1;
				end
				OP_NARROW_MOVE:
				begin
					next_s.result = ftp_extend(narrow_in, NARROW_W, s.int_mode); // [RL4]
					next_s.result_we = 1'b1;
				end
				OP_UNPACK_INIT:
				begin
					// Initial fill comes from the addressed byte, external memory if enabled, else ROM
					next_s.ptr = acc_in; // [RL18]
					next_s.src = external_memory_enable_bit ? SRC_EXT : SRC_ROM;
					next_s.addr = acc_in;
					next_s.req = 1'b1;
					next_s.init_load = 1'b1;
					next_s.fstate = ST_LOAD;
				end
				OP_BIT_FETCH:
				begin
					next_s.want = {1'b0, fetch_len_m1} + 4'h1; // [RL19]
					next_s.got = 4'h0;
					next_s.bits = BYTE_ZERO;
					next_s.fstate = ST_SHIFT;
				end
				default:
				begin
				end
			endcase
		end

		// Pending request survives until acknowledged; a new wrap wins over the clear
		if (level2_ack)
			next_s.irq2_pend = 1'b0;
		if (timer_wrap)
			next_s.irq2_pend = 1'b1; // [RL7]
		next_s.irq2_req = next_s.irq2_pend && level2_enable_bit && int_enable
			&& !int_in_service; // [RL7] [RL24]

		// Sequencer; new fetch or init instructions are not issued while busy
		case (s.fstate)
			ST_IDLE:
			begin
			end
			ST_LOAD:
				if (mem_ack)
				begin
					next_s.req = 1'b0;
					next_s.shifter = mem_data;
					next_s.used = 4'h0; // [RL18]
					if (s.src != SRC_RAM)
						next_s.ptr = s.ptr + 14'h0001; // [RL20] [RL21]
					next_s.init_load = 1'b0;
					next_s.fstate = s.init_load ? ST_IDLE : ST_SHIFT;
				end
			ST_SHIFT:
				if (s.used == BITS_PER_BYTE)
				begin
					// Out of bits: refill before the fetch goes on
					next_s.src = pick_src(ram_source_bit, external_memory_enable_bit); // [RL22] [RL23]
					next_s.addr = ram_source_bit ? {6'h00, x_index} : s.ptr; // [RL20] [RL21]
					next_s.req = 1'b1;
					next_s.fstate = ST_LOAD;
				end
				else
				begin
					next_s.bits = next_bits;
					next_s.shifter = {s.shifter[6:0], 1'b0};
					next_s.used = s.used + 4'h1;
					next_s.got = s.got + 4'h1;
					if (s.got + 4'h1 == s.want)
					begin
						next_s.result = ftp_extend(next_bits, s.want, s.int_mode); // [RL25]
						next_s.result_we = 1'b1; // [RL19]
						next_s.fstate = ST_IDLE;
					end
				end
			default:
				next_s.fstate = ST_IDLE;
		endcase
		next_s.busy = (next_s.fstate != ST_IDLE);
	end

	// State register; the status flag has no defined power-up value, cleared here
	always_ff @(posedge core_clk)
	begin
		if (rst)
			s <= '{status: 1'b0, int_mode: 1'b0, saved_status: 1'b0, saved_int_mode: 1'b0,
				branch: 1'b0, result: 14'h0000, result_we: 1'b0, irq2_pend: 1'b0,
				irq2_req: 1'b0, ptr: PTR_RST, shifter: BYTE_ZERO, used: BITS_PER_BYTE,
				want: 4'h1, got: 4'h0, bits: BYTE_ZERO, fstate: ST_IDLE, init_load: 1'b0,
				req: 1'b0, src: SRC_ROM, addr: PTR_RST, busy: 1'b0};
		else
			s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign branch_take = s.branch;
	assign status_flag = s.status;
	assign int_mode_flag = s.int_mode;
	assign result_data = s.result;
	assign result_we = s.result_we;
	assign level2_irq = s.irq2_req;
	assign mem_req = s.req;
	assign mem_src = s.src;
	assign mem_addr = s.addr;
	assign unpack_busy = s.busy;

	chk_branch_cond: assert property (@(posedge core_clk) disable iff (rst) // [RL1]
		(instr_valid && (instr_op == OP_BRANCH || instr_op == OP_SHORT_BRANCH
		|| instr_op == OP_CALL))
		|=> (branch_take == $past(status_flag)))
		else $error("branch taken against status flag");
	chk_int_return: assert property (@(posedge core_clk) disable iff (rst) // [RL2]
		(instr_valid && instr_op == OP_INT_RET && !int_enter)
		|=> (int_mode_flag == $past(s.saved_int_mode)
		&& status_flag == $past(s.saved_status)))
		else $error("flags not restored on return");
	chk_intmode_set: assert property (@(posedge core_clk) disable iff (rst) // [RL3]
		(instr_valid && instr_op == OP_INTEGER) |=> int_mode_flag)
		else $error("integer mode not set");
	chk_narrow_fill: assert property (@(posedge core_clk) disable iff (rst) // [RL4]
		(instr_valid && instr_op == OP_NARROW_MOVE && int_mode_flag && narrow_in[7])
		|=> (result_we && result_data[13:8] == 6'h00))
		else $error("integer mode did not zero fill");
	chk_irq2_gate: assert property (@(posedge core_clk) disable iff (rst) // [RL24]
		level2_irq |-> ($past(level2_enable_bit) && $past(int_enable)))
		else $error("level-2 request without enable");
	chk_ram_no_inc: assert property (@(posedge core_clk) disable iff (rst) // [RL21]
		(s.fstate == ST_LOAD && mem_ack && mem_src == SRC_RAM) |=> $stable(s.ptr))
		else $error("pointer moved on RAM refill");
	chk_fetch_done: assert property (@(posedge core_clk) disable iff (rst) // [RL19]
		(instr_valid && instr_op == OP_BIT_FETCH && fetch_len_m1 == 3'h0 && !unpack_busy
		&& s.used != BITS_PER_BYTE) |=> ##1 (result_we && !unpack_busy))
		else $error("one-bit fetch not finished in two cycles");

endmodule
`default_nettype wire

// File: ftp_mem_model.sv
// Byte store at the far side of the unpacker port: internal ROM, RAM and external memory.
// Assumes mem_req is held until mem_ack; wait_cyc sets how many idle cycles precede an answer.
`timescale 1ns/100ps
`default_nettype none
module ftp_mem_model
	import ftp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] wait_cyc,
	input wire logic mem_req,
	input wire ftp_pkg::ftp_src_t mem_src,
	input wire logic [13:0] mem_addr,
	output logic [7:0] mem_data,
	output logic mem_ack
);
	import ftp_pkg::*;

	logic [3:0] cnt;

	////////////////////////////////////////////////////////////////////////////////
	// One-cycle answer; outside it the data lines toggle so stale bytes never look valid
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cnt <= 4'h0;
			mem_ack <= 1'b0;
			mem_data <= 8'hA5;
		end
		else if (mem_ack || !mem_req)
		begin
			cnt <= 4'h0;
			mem_ack <= 1'b0;
			mem_data <= ~mem_data;
		end
		else if (cnt == wait_cyc)
		begin
			mem_ack <= 1'b1;
			mem_data <= mem_addr[7:0] ^ ((mem_src == SRC_RAM) ? 8'hC3 :
				(mem_src == SRC_EXT) ? 8'h3C : 8'h5A);
		end
		else
		begin
			cnt <= cnt + 4'h1;
			mem_data <= ~mem_data;
		end
	end
endmodule
`default_nettype wire

// File: ftp_pitch.sv
// Pitch register and pitch-period counter with level-1 request and excitation window.
// Assumes sample_tick is a one-cycle strobe per speech sample from the synthesizer.
`timescale 1ns/100ps
`default_nettype none
module ftp_pitch
	import ftp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic pitch_load,
	input wire logic [13:0] pitch_data,
	input wire logic speech_start,
	input wire logic sample_tick,
	input wire logic lattice_synthesis_mode,
	output logic level1_irq,
	output logic excitation_on
);
	import ftp_pkg::*;

	typedef struct packed {
		logic [13:0] period_cnt;
		logic [13:0] pitch;
		logic irq;
		logic excite;
	} ftp_pitch_state_t;

	ftp_pitch_state_t s;
	ftp_pitch_state_t next_s;
	logic [14:0] diff;
	logic [14:0] sum;

	////////////////////////////////////////////////////////////////////////////////
	// Step the counter; a borrow means it went below zero and gets the period back
	always_comb
	begin
		next_s = s;
		next_s.irq = 1'b0;
		diff = {1'b0, s.period_cnt} - {1'b0, PITCH_STEP};
		sum = diff + {1'b0, s.pitch};
		if (pitch_load)
			next_s.pitch = pitch_data; // [RL11]
		if (speech_start)
			next_s.period_cnt = PITCH_RST; // [RL11]
		else if (lattice_synthesis_mode && sample_tick)
		begin
			if (diff[14])
			begin
				next_s.period_cnt = sum[13:0]; // [RL13]
				next_s.irq = (sum[13:0] < PITCH_IRQ_LIM); // [RL14]
			end
			else
			begin
				next_s.period_cnt = diff[13:0]; // [RL12]
				next_s.irq = (diff[13:0] < PITCH_IRQ_LIM)
					&& (s.period_cnt >= PITCH_IRQ_LIM); // [RL14]
			end
		end
		next_s.excite = lattice_synthesis_mode && (next_s.period_cnt <= EXCITE_LIM); // [RL15]
	end

	// State register
	always_ff @(posedge core_clk)
	begin
		if (rst)
			s <= '{period_cnt: PITCH_RST, pitch: PITCH_RST, irq: 1'b0, excite: 1'b0};
		else
			s <= next_s;
	end

	assign level1_irq = s.irq;
	assign excitation_on = s.excite;

	chk_pitch_step_down: assert property (@(posedge core_clk) disable iff (rst) // [RL12]
		(lattice_synthesis_mode && sample_tick && !speech_start && s.period_cnt >= PITCH_STEP)
		|=> (s.period_cnt == $past(s.period_cnt) - PITCH_STEP))
		else $error("pitch counter did not step by 020h");
	chk_excite_window: assert property (@(posedge core_clk) disable iff (rst) // [RL15]
		excitation_on |-> (s.period_cnt <= EXCITE_LIM))
		else $error("excitation outside window");

endmodule
`default_nettype wire

// File: ftp_pkg.sv
// Constants, types and shared decode for the flags, timer, pitch and unpack block.
// Assumes a single 25 MHz core clock and a synchronous active-high reset.
package ftp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Internal tick: one prescaler step every 16 core clocks
	localparam int TICK_DIV = 16;
	localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

	// Timer and prescaler
	localparam logic [7:0] TIMER_RST = 8'h00;
	localparam logic [7:0] DIV_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Pitch-period counter figures
	localparam logic [13:0] PITCH_RST = 14'h0000;
	localparam logic [13:0] PITCH_STEP = 14'h0020;
	localparam logic [13:0] PITCH_IRQ_LIM = 14'h0200;
	localparam logic [13:0] EXCITE_LIM = 14'h0140;

	// Unpacker
	localparam logic [13:0] PTR_RST = 14'h0000;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] NARROW_W = 4'h8;

	// Instruction codes presented by the execution unit
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_BRANCH = 4'h1,
		OP_SHORT_BRANCH = 4'h2,
		OP_CALL = 4'h3,
		OP_INT_RET = 4'h4,
		OP_INTEGER = 4'h5,
		OP_SIGN_EXTEND = 4'h6,
		OP_TIMER_LOAD = 4'h7,
		OP_TIMER_READ = 4'h8,
		OP_DIVIDER_LOAD = 4'h9,
		OP_PITCH_LOAD = 4'hA,
		OP_UNPACK_INIT = 4'hB,
		OP_BIT_FETCH = 4'hC,
		OP_NARROW_MOVE = 4'hD
	} ftp_op_t;

	// Unpacker data source
	typedef enum logic [1:0] {
		SRC_ROM = 2'b00,
		SRC_RAM = 2'b01,
		SRC_EXT = 2'b10
	} ftp_src_t;

	// Unpacker sequencer, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOAD = 3'b010,
		ST_SHIFT = 3'b100
	} ftp_state_t;

	// Widen n low bits of v to 14 bits, zero fill or sign extend
	function automatic logic [13:0] ftp_extend(input logic [7:0] v, input logic [3:0] n,
		input logic int_mode);
		logic [13:0] r;
		logic sgn;
		r = 14'h0000;
		sgn = v[3'(n - 4'h1)];
		for (int i = 0; i < 14; i++)
		begin
			if (i < int'(n))
				r[i] = (i < 8) ? v[i[2:0]] : 1'b0;
			else
				r[i] = int_mode ? 1'b0 : sgn;
		end
		return r;
	endfunction

endpackage

// File: ftp_timer.sv
// Event timer with reloadable prescaler driven by a 1/16 core-clock tick.
// Assumes load strobes are single-cycle pulses from the instruction decoder.
`timescale 1ns/100ps
`default_nettype none
module ftp_timer
	import ftp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic timer_load,
	input wire logic divider_load,
	input wire logic [7:0] load_data,
	output logic [7:0] timer_value,
	output logic timer_wrap
);
	import ftp_pkg::*;

	typedef struct packed {
		logic [3:0] tick_cnt;
		logic [7:0] divider;
		logic [7:0] preset;
		logic [7:0] timer;
		logic armed;
		logic wrap;
	} ftp_timer_state_t;

	ftp_timer_state_t s;
	ftp_timer_state_t next_s;
	logic tick;

	////////////////////////////////////////////////////////////////////////////////
	// Count, reload and load; a timer load in the same cycle overrides the count
	always_comb
	begin
		next_s = s;
		next_s.wrap = 1'b0;
		tick = (s.tick_cnt == TICK_LAST);
		next_s.tick_cnt = s.tick_cnt + 4'h1; // Free-running divide by 16 [RL10]
		if (tick && s.armed) // Idle until first loaded [RL8]
		begin
			if (s.divider == BYTE_ZERO)
			begin
				next_s.divider = s.preset; // [RL9]
				next_s.timer = s.timer - 8'h01; // [RL5]
				if (s.timer == BYTE_ZERO)
					next_s.wrap = 1'b1; // [RL7]
			end
			else
				next_s.divider = s.divider - 8'h01;
		end
		if (divider_load)
		begin
			next_s.preset = load_data; // [RL6]
			if (!s.armed)
				next_s.divider = load_data; // [RL6]
		end
		if (timer_load)
		begin
			next_s.timer = load_data; // [RL6]
			next_s.armed = 1'b1; // Stays armed for good [RL8]
		end
	end

	// State register
	always_ff @(posedge core_clk)
	begin
		if (rst)
			s <= '{tick_cnt: 4'h0, divider: DIV_RST, preset: DIV_RST, timer: TIMER_RST,
				armed: 1'b0, wrap: 1'b0};
		else
			s <= next_s;
	end

	assign timer_value = s.timer;
	assign timer_wrap = s.wrap;

	chk_timer_wrap_pulse: assert property (@(posedge core_clk) disable iff (rst) // [RL7]
		(tick && s.armed && s.divider == BYTE_ZERO && s.timer == BYTE_ZERO && !timer_load)
		|=> (timer_wrap && timer_value == 8'hFF))
		else $error("timer wrap not flagged");
	chk_timer_unarmed_hold: assert property (@(posedge core_clk) disable iff (rst) // [RL8]
		(!s.armed && !timer_load) |=> $stable(timer_value))
		else $error("timer moved before first load");

endmodule
`default_nettype wire

// File: tb_ftp_core.sv
// Self-checking bench for ftp_core: flags, timer, pitch counter and unpacker.
// Assumes ftp_mem_model answers the byte port; inputs change on falling clock edges.
`timescale 1ns/100ps
`default_nettype none
module tb_ftp_core;
	import ftp_pkg::*;

	logic core_clk, rst, instr_valid, status_we, status_in, int_enter, int_enable;
	logic int_in_service, level2_ack, level2_enable_bit, external_memory_enable_bit;
	logic ram_source_bit, lattice_synthesis_mode, speech_start, sample_tick, mem_ack;
	logic branch_take, status_flag, int_mode_flag, result_we, level2_irq, level1_irq;
	logic excitation_on, mem_req, unpack_busy;
	logic [13:0] acc_in, result_data, mem_addr;
	logic [7:0] narrow_in, x_index, mem_data, event_timer;
	logic [2:0] fetch_len_m1;
	logic [3:0] wait_cyc;
	ftp_op_t instr_op;
	ftp_src_t mem_src;
	int miscompares = 0;
	int checked = 0;
	time t_low = 0;

	ftp_core i_ftp_core (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
		.instr_op(instr_op), .acc_in(acc_in), .narrow_in(narrow_in),
		.fetch_len_m1(fetch_len_m1), .x_index(x_index), .status_we(status_we),
		.status_in(status_in), .int_enter(int_enter), .int_enable(int_enable),
		.int_in_service(int_in_service), .level2_ack(level2_ack),
		.level2_enable_bit(level2_enable_bit),
		.external_memory_enable_bit(external_memory_enable_bit),
		.ram_source_bit(ram_source_bit), .lattice_synthesis_mode(lattice_synthesis_mode),
		.speech_start(speech_start), .sample_tick(sample_tick), .mem_data(mem_data),
		.mem_ack(mem_ack), .branch_take(branch_take), .status_flag(status_flag),
		.int_mode_flag(int_mode_flag), .result_data(result_data), .result_we(result_we),
		.level2_irq(level2_irq), .level1_irq(level1_irq), .excitation_on(excitation_on),
		.event_timer(event_timer), .mem_req(mem_req), .mem_src(mem_src),
		.mem_addr(mem_addr), .unpack_busy(unpack_busy));

	ftp_mem_model i_ftp_mem_model (.core_clk(core_clk), .rst(rst), .wait_cyc(wait_cyc),
		.mem_req(mem_req), .mem_src(mem_src), .mem_addr(mem_addr), .mem_data(mem_data),
		.mem_ack(mem_ack));

	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers: compare, closing report, cycle waits, instruction issue
	task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Bounded wait step; a hang counts as a mismatch and closes the run
	task automatic step(inout int n);
		cyc(1);
		n++;
		if (n > 300)
		begin
			miscompares++;
			end_sim();
		end
	endtask

	// Back-to-back calls let one edge pass so valid is never lowered and raised at once
	task automatic issue(input ftp_op_t op, input logic [13:0] a);
		if (t_low == $time)
			cyc(1);
		instr_valid = 1'b1;
		instr_op = op;
		acc_in = a;
		cyc(1);
		instr_valid = 1'b0;
		t_low = $time;
	endtask

	task automatic set_status(input logic v);
		status_we = 1'b1;
		status_in = v;
		cyc(1);
		status_we = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Conditional branches, arithmetic mode, narrow widening, save and restore
	task automatic t_flags();
		ftp_op_t ops[3] = '{OP_BRANCH, OP_SHORT_BRANCH, OP_CALL};
		for (int s = 0; s < 2; s++)
		begin
			set_status(s[0]);
			foreach (ops[i])
			begin
				issue(ops[i], 14'h0000);
				chk({13'h0000, branch_take}, 14'(s));
			end
		end
		issue(OP_INTEGER, 14'h0000);
		chk({13'h0000, int_mode_flag}, 14'h0001);
		narrow_in = 8'h85;
		issue(OP_NARROW_MOVE, 14'h0000);
		chk(result_data, 14'h0085);
		issue(OP_SIGN_EXTEND, 14'h0000);
		chk({13'h0000, int_mode_flag}, 14'h0000);
		issue(OP_NARROW_MOVE, 14'h0000);
		chk(result_data, 14'h3F85);
		set_status(1'b1);
		issue(OP_INTEGER, 14'h0000);
		int_enter = 1'b1;
		cyc(1);
		int_enter = 1'b0;
		set_status(1'b0);
		issue(OP_SIGN_EXTEND, 14'h0000);
		issue(OP_INT_RET, 14'h0000);
		chk({12'h000, status_flag, int_mode_flag}, 14'h0003);
		$display("flags test done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Timer arming, prescaler period, preset reload and the held level-2 request
	task automatic wait_tmr(input logic [7:0] v, output int n);
		n = 0;
		while (event_timer !== v)
			step(n);
	endtask

	task automatic t_timer();
		int n;
		issue(OP_DIVIDER_LOAD, 14'h0002);
		cyc(100);
		chk({6'h00, event_timer}, 14'h0000);
		issue(OP_TIMER_LOAD, 14'h0001);
		chk({6'h00, event_timer}, 14'h0001);
		wait_tmr(8'h00, n);
		wait_tmr(8'hFF, n);
		chk(14'(n), 14'h0030);
		cyc(2);
		chk({13'h0000, level2_irq}, 14'h0000);
		issue(OP_INTEGER, 14'h0000);
		issue(OP_TIMER_READ, 14'h0000);
		chk(result_data, 14'h00FF);
		level2_enable_bit = 1'b1;
		cyc(2);
		chk({13'h0000, level2_irq}, 14'h0001);
		int_in_service = 1'b1;
		cyc(2);
		chk({13'h0000, level2_irq}, 14'h0000);
		int_in_service = 1'b0;
		level2_ack = 1'b1;
		cyc(1);
		level2_ack = 1'b0;
		cyc(2);
		chk({13'h0000, level2_irq}, 14'h0000);
		wait_tmr(8'hFD, n);
		// Latch only: the running prescaler finishes its current period from preset two
		issue(OP_DIVIDER_LOAD, 14'h0000);
		wait_tmr(8'hFC, n);
		chk(14'(n + 1), 14'h0030);
		wait_tmr(8'hFB, n);
		chk(14'(n), 14'h0010);
		$display("timer test done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Pitch-period counter: steps, borrow add, level-1 pulse, excitation window
	// Returns in the cycle in which the one-cycle level-1 pulse stands
	task automatic tick();
		sample_tick = 1'b1;
		cyc(1);
		sample_tick = 1'b0;
	endtask

	task automatic start_speech();
		speech_start = 1'b1;
		cyc(1);
		speech_start = 1'b0;
	endtask

	task automatic t_pitch();
		lattice_synthesis_mode = 1'b1;
		issue(OP_PITCH_LOAD, 14'h0242);
		start_speech();
		for (int k = 1; k < 20; k++)
		begin
			tick();
			chk({13'h0000, level1_irq}, 14'(k == 3));
			chk({13'h0000, excitation_on}, 14'(k >= 9 && k <= 18));
			cyc(1);
		end
		issue(OP_PITCH_LOAD, 14'h00C2);
		start_speech();
		tick();
		chk({12'h000, level1_irq, excitation_on}, 14'h0003);
		$display("pitch test done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Unpacker: init fill, fetch widths, refills from each source, fill by mode
	task automatic fetch(input logic [3:0] len, input logic [13:0] exp, input logic refill,
		input ftp_src_t src, input logic [13:0] adr);
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		fetch_len_m1 = 3'(len - 4'h1);
		issue(OP_BIT_FETCH, 14'h0000);
		while (result_we !== 1'b1)
		begin
			if (mem_req === 1'b1 && !seen)
			begin
				seen = 1'b1;
				chk({12'h000, mem_src}, {12'h000, src});
				chk(mem_addr, adr);
			end
			step(n);
		end
		chk(result_data, exp);
		chk({13'h0000, seen}, {13'h0000, refill});
		cyc(1);
	endtask

	task automatic t_unpack();
		int n;
		n = 0;
		wait_cyc = 4'h5;
		issue(OP_UNPACK_INIT, 14'h0090);
		while (mem_req !== 1'b1)
			step(n);
		chk(mem_addr, 14'h0090);
		while (unpack_busy !== 1'b0)
			step(n);
		issue(OP_INTEGER, 14'h0000);
		fetch(4'h8, 14'h00CA, 1'b0, SRC_ROM, 14'h0000);
		issue(OP_SIGN_EXTEND, 14'h0000);
		wait_cyc = 4'h0;
		fetch(4'h3, 14'h3FFE, 1'b1, SRC_ROM, 14'h0091);
		issue(OP_INTEGER, 14'h0000);
		fetch(4'h5, 14'h000B, 1'b0, SRC_ROM, 14'h0000);
		ram_source_bit = 1'b1;
		x_index = 8'h33;
		fetch(4'h8, 14'h00F0, 1'b1, SRC_RAM, 14'h0033);
		ram_source_bit = 1'b0;
		external_memory_enable_bit = 1'b1;
		issue(OP_SIGN_EXTEND, 14'h0000);
		fetch(4'h4, 14'h3FFA, 1'b1, SRC_EXT, 14'h0092);
		fetch(4'h1, 14'h3FFF, 1'b0, SRC_EXT, 14'h0000);
		$display("unpack test done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and main sequence
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial
	begin
		#4000000;
		miscompares++;
		end_sim();
	end

	initial
	begin
		{rst, int_enable} = 2'b11;
		{instr_valid, status_we, status_in, int_enter, int_in_service, level2_ack} = 6'h00;
		{level2_enable_bit, external_memory_enable_bit, ram_source_bit} = 3'h0;
		{lattice_synthesis_mode, speech_start, sample_tick} = 3'h0;
		instr_op = OP_NONE;
		acc_in = 14'h0000;
		narrow_in = 8'h00;
		x_index = 8'h00;
		fetch_len_m1 = 3'h0;
		wait_cyc = 4'h0;
		cyc(4);
		rst = 1'b0;
		t_flags();
		t_timer();
		t_pitch();
		t_unpack();
		end_sim();
	end
endmodule
`default_nettype wire
